// ===== dv/dvl_drive_model.sv
// Drive-side model: throttle, battery sense and slope speed flag
`timescale 1ns/1ps
module dvl_drive_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic slope, // Rolling down a slope
  input wire logic [6:0] throttle, // Rider demand
  input wire logic [9:0] batt_set, // Battery level
  input wire logic [9:0] comp_set, // Load compensation level
  output logic [9:0] batt_dv, // Battery voltage
  output logic [6:0] demand_pct, // Demand percent
  output logic over_speed, // Speed above maximum
  output logic [9:0] comp_dv // Compensation voltage
);
  // Gravity pushes past top speed on a slope whatever the throttle does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {batt_dv, demand_pct, over_speed, comp_dv} <= '0;
    end else begin
      batt_dv <= batt_set;
      demand_pct <= throttle;
      over_speed <= slope;
      comp_dv <= comp_set;
    end
  end
endmodule : dvl_drive_model

// ===== dv/dvl_limiter_tb_top.sv
// Self-checking bench for the downhill voltage limiter
`timescale 1ns/1ps
module dvl_limiter_tb_top;
  localparam int TC = 2;
  logic clk = 0, rst_n = 0, read = 0, write = 0, slope = 0;
  logic [4:0] address = '0;
  logic [31:0] writedata = '0, readdata, q;
  logic [3:0] byteenable = 4'hF;
  logic waitrequest, over_speed, downhill;
  logic [6:0] throttle = '0, demand_pct;
  logic [9:0] batt_set = 10'h190, comp_set = '0;
  logic [9:0] batt_dv, comp_dv, vlimit_dv;
  logic [10:0] vmax_dv;
  logic [4:0] ad[5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
  logic [31:0] dv[5] = '{32'h106, 32'h46, 32'h64, 32'h14, 32'h14};
  int sc[3] = '{60, 80, 100};
  int n_mismatch = 0, num_checks = 0, cyc = 0, b, c, m;
  always #2.5 clk = ~clk;
  dvl_limiter #(.TICK_CYCLES(TC)) u_dvl_limiter (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .batt_dv(batt_dv), .demand_pct(demand_pct),
    .over_speed(over_speed), .comp_dv(comp_dv), .vlimit_dv(vlimit_dv),
    .vmax_dv(vmax_dv), .downhill(downhill));
  dvl_drive_model u_dvl_drive_model (.clk(clk), .rst_n(rst_n),
    .slope(slope), .throttle(throttle), .batt_set(batt_set),
    .comp_set(comp_set), .batt_dv(batt_dv), .demand_pct(demand_pct),
    .over_speed(over_speed), .comp_dv(comp_dv));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_out(string nm, logic [10:0] e, logic [10:0] g);
    chk_reg(nm, {21'h0, e}, {21'h0, g});
  endtask : chk_out
  // Entered just after an edge; the trailing edge keeps strobes apart
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hD8E2));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      bus(0, ad[i], 0);
      chk_reg("default", dv[i], q);
    end
    bus(0, 5'h18, 0);
    chk_reg("unmapped", 0, q);
    // A write with partial lanes completes but must leave settings alone
    byteenable <= 4'h3;
    bus(1, 5'h08, 32'h32);
    byteenable <= 4'hF;
    bus(0, 5'h08, 0);
    chk_reg("thr kept", 32'h64, q);
    bus(0, 5'h14, 0);
    chk_reg("status def", 32'h106, q);
    batt_set <= 10'h3FF;
    bus(1, 5'h00, 32'h3FF);
    bus(0, 5'h00, 0);
    chk_reg("ceil sat", 32'h280, q);
    chk_out("vlim top", 11'h280, {1'b0, vlimit_dv});
    bus(1, 5'h00, 32'h106);
    for (int i = 0; i < 8; i++) begin
      b = 100 + $urandom % 400;
      c = $urandom % 100;
      batt_set <= 10'(b);
      comp_set <= 10'(c);
      repeat (3) @(posedge clk);
      b = (b < 262) ? b : 262;
      chk_out("vlim", 11'(b), {1'b0, vlimit_dv});
      chk_out("vmax", 11'(b + c), vmax_dv);
    end
    batt_set <= 10'h190;
    throttle <= 7'h64;
    slope <= 1'b1;
    repeat (200) @(posedge clk);
    chk_out("dh off", 0, {10'h0, downhill});
    chk_out("vlim off", 11'h106, {1'b0, vlimit_dv});
    bus(1, 5'h08, 32'h3C);
    bus(1, 5'h0C, 32'h05);
    bus(1, 5'h10, 32'h05);
    throttle <= 7'h3C;
    repeat (100) @(posedge clk);
    chk_out("dh low", 0, {10'h0, downhill});
    for (int i = 0; i < 3; i++) begin
      bus(1, 5'h04, 32'(sc[i]));
      throttle <= 7'h64;
      repeat (4) @(posedge clk);
      chk_out("dh on", 1, {10'h0, downhill});
      repeat (251 * TC) @(posedge clk);
      m = int'(vlimit_dv) - (262 - sc[i] / 4);
      chk_out("mid", 1, 11'(m >= -1 && m <= 1));
      repeat (251 * TC + 8) @(posedge clk);
      chk_out("vlim red", 11'(262 - sc[i] / 2), {1'b0, vlimit_dv});
      bus(0, 5'h14, 0);
      chk_reg("status", 32'h30000 + 32'(262 - sc[i] / 2), q);
      slope <= 1'b0;
      repeat (4) @(posedge clk);
      chk_out("dh rec", 0, {10'h0, downhill});
      repeat (502 * TC + 8) @(posedge clk);
      chk_out("vlim rec", 11'h106, {1'b0, vlimit_dv});
      slope <= 1'b1;
    end
    // Reset lands as the slope is raised again, before over_speed can follow, and must restore the defaults
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, 5'h14, 0);
    chk_reg("status rst", 32'h106, q);
    test_done();
  end
endmodule : dvl_limiter_tb_top

// ===== hw/dvl_limiter.sv
// Downhill motor voltage limiter with Avalon-MM register slave
`timescale 1ns/1ps
module dvl_limiter #(
  parameter int TICK_CYCLES = dvl_pkg::TICK_CYC
) (
  input wire logic clk, // 200 MHz clock
  input wire logic rst_n, // Asynchronous reset
  input wire logic [4:0] address, // Byte address
  input wire logic read, // Read request
  input wire logic write, // Write request
  input wire logic [31:0] writedata, // Write data
  input wire logic [3:0] byteenable, // Byte lanes
  output logic [31:0] readdata, // Read data
  output logic waitrequest, // Stall
  input wire logic [9:0] batt_dv, // Battery voltage
  input wire logic [6:0] demand_pct, // Throttle demand
  input wire logic over_speed, // Speed above maximum
  input wire logic [9:0] comp_dv, // Load compensation voltage
  output logic [9:0] vlimit_dv, // Applied voltage ceiling
  output logic [10:0] vmax_dv, // Ceiling plus compensation
  output logic downhill // Reduction ramping in or held
);
  localparam int TCW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [9:0] ceil;
    logic [6:0] scale;
    logic [6:0] thr;
    logic [4:0] tdn;
    logic [4:0] trec;
    logic cfg;
    dvl_pkg::dvl_state_e st;
    logic [TCW-1:0] tcnt;
    logic [15:0] red;
    logic [9:0] vlim;
    logic [10:0] vmax;
    logic dh;
  } dvl_st_s;

  localparam dvl_st_s S_RST = '{
    ack: 1'b0, rdata: 32'h0, ceil: dvl_pkg::CEIL_DEF,
    scale: dvl_pkg::SCALE_DEF, thr: dvl_pkg::THR_DEF,
    tdn: dvl_pkg::TIME_DEF, trec: dvl_pkg::TIME_DEF, cfg: 1'b0,
    st: dvl_pkg::DVL_NORMAL, tcnt: '0, red: 16'h0,
    vlim: 10'h0, vmax: 11'h0, dh: 1'b0};

  function automatic logic [31:0] sat(input logic [31:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
    sat = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : sat

  dvl_st_s s_r;
  dvl_st_s s_nxt;
  logic tick;
  logic dh_c;
  logic wr_ok;
  logic [15:0] full_fx;
  logic [11:0] ticks_dn;
  logic [11:0] ticks_rec;
  logic [15:0] step_dn;
  logic [15:0] step_rec;
  logic [9:0] red_dv;
  logic [9:0] ceil_eff;
  logic [9:0] vlim_c;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    tick = (s_r.tcnt == TCW'(TICK_CYCLES - 1));
    s_nxt.tcnt = tick ? '0 : s_r.tcnt + 1'b1;
    // One wait cycle per access; read data is captured during it
    waitrequest = (read | write) & ~s_r.ack;
    s_nxt.ack = (read | write) & ~s_r.ack;
    if (read & ~s_r.ack) begin
      case (address)
        dvl_pkg::ADDR_CEIL: s_nxt.rdata = 32'(s_r.ceil);
        dvl_pkg::ADDR_SCALE: s_nxt.rdata = 32'(s_r.scale);
        dvl_pkg::ADDR_THR: s_nxt.rdata = 32'(s_r.thr);
        dvl_pkg::ADDR_TDN: s_nxt.rdata = 32'(s_r.tdn);
        dvl_pkg::ADDR_TREC: s_nxt.rdata = 32'(s_r.trec);
        dvl_pkg::ADDR_STAT: begin
          s_nxt.rdata = 32'(s_r.vlim);
          s_nxt.rdata[dvl_pkg::STAT_DH_BIT] = s_r.dh;
          s_nxt.rdata[dvl_pkg::STAT_CFG_BIT] = s_r.cfg;
        end
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    // Out-of-range settings saturate so the limiter never runs off-spec
    wr_ok = write & s_r.ack & (byteenable == 4'hF);
    if (wr_ok) begin
      case (address)
        dvl_pkg::ADDR_CEIL: s_nxt.ceil =
          10'(sat(writedata, 32'h0, 32'(dvl_pkg::CEIL_MAX)));
        dvl_pkg::ADDR_SCALE: s_nxt.scale = 7'(sat(writedata,
          32'(dvl_pkg::SCALE_MIN), 32'(dvl_pkg::SCALE_MAX)));
        dvl_pkg::ADDR_THR: s_nxt.thr = 7'(sat(writedata,
          32'(dvl_pkg::THR_MIN), 32'(dvl_pkg::THR_MAX)));
        dvl_pkg::ADDR_TDN: s_nxt.tdn = 5'(sat(writedata,
          32'(dvl_pkg::TIME_MIN), 32'(dvl_pkg::TIME_MAX)));
        dvl_pkg::ADDR_TREC: s_nxt.trec = 5'(sat(writedata,
          32'(dvl_pkg::TIME_MIN), 32'(dvl_pkg::TIME_MAX)));
        default: ;
      endcase
      if (address <= dvl_pkg::ADDR_TREC) begin
        s_nxt.cfg = 1'b1;
      end
    end
    // Threshold at its top disables the downhill path entirely
    dh_c = over_speed && (s_r.thr != dvl_pkg::THR_MAX) &&
           (demand_pct > s_r.thr);
    full_fx = 16'(s_r.scale >> dvl_pkg::RED_SHIFT) << dvl_pkg::FRAC;
    ticks_dn = 12'(32'(s_r.tdn) * dvl_pkg::TICKS_PER_DS);
    ticks_rec = 12'(32'(s_r.trec) * dvl_pkg::TICKS_PER_DS);
    // Steps round up so the full change lands within the set time
    step_dn = 16'((32'(full_fx) + 32'(ticks_dn) - 1) / 32'(ticks_dn));
    step_rec = 16'((32'(full_fx) + 32'(ticks_rec) - 1) / 32'(ticks_rec));
    case (s_r.st)
      dvl_pkg::DVL_NORMAL: begin
        s_nxt.red = 16'h0;
        if (dh_c) begin
          s_nxt.st = dvl_pkg::DVL_DOWN;
        end
      end
      dvl_pkg::DVL_DOWN: begin
        if (!dh_c) begin
          s_nxt.st = dvl_pkg::DVL_RECOV;
        end else if (tick) begin
          s_nxt.red = (s_r.red + step_dn >= full_fx) ? full_fx :
                      s_r.red + step_dn;
        end else if (s_r.red > full_fx) begin
          s_nxt.red = full_fx;
        end
      end
      dvl_pkg::DVL_RECOV: begin
        if (dh_c) begin
          s_nxt.st = dvl_pkg::DVL_DOWN;
        end else if (s_r.red == 16'h0) begin
          s_nxt.st = dvl_pkg::DVL_NORMAL;
        end else if (tick) begin
          s_nxt.red = (s_r.red <= step_rec) ? 16'h0 :
                      s_r.red - step_rec;
        end
      end
      default: begin
        s_nxt.st = dvl_pkg::DVL_NORMAL;
        s_nxt.red = 16'h0;
      end
    endcase
    red_dv = 10'(s_r.red >> dvl_pkg::FRAC);
    ceil_eff = (s_r.ceil > red_dv) ? s_r.ceil - red_dv : 10'h0;
    vlim_c = (batt_dv < ceil_eff) ? batt_dv : ceil_eff;
    s_nxt.vlim = vlim_c;
    s_nxt.vmax = 11'(vlim_c) + 11'(comp_dv);
    s_nxt.dh = (s_r.st == dvl_pkg::DVL_DOWN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign readdata = s_r.rdata;
  assign vlimit_dv = s_r.vlim;
  assign vmax_dv = s_r.vmax;
  assign downhill = s_r.dh;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_down_tick;
    (s_r.st == dvl_pkg::DVL_DOWN) && dh_c && tick &&
    (s_r.red + step_dn < full_fx);
  endsequence
  sequence s_rec_tick;
    (s_r.st == dvl_pkg::DVL_RECOV) && !dh_c && tick &&
    (s_r.red > step_rec);
  endsequence

  a_ceil_bound: assert property (vlimit_dv <= $past(s_r.ceil))
    else $error("voltage ceiling exceeded");
  a_batt_cap: assert property (vlimit_dv <= $past(batt_dv))
    else $error("ceiling above battery voltage");
  a_comp_add: assert property (
    vmax_dv == 11'(vlimit_dv) + 11'($past(comp_dv)))
    else $error("compensation not added");
  // The flag is registered from the state, so it trails it by one cycle
  a_enter_down: assert property (
    (s_r.st == dvl_pkg::DVL_NORMAL) && dh_c |=>
    (s_r.st == dvl_pkg::DVL_DOWN) ##1 downhill)
    else $error("downhill not entered");
  a_red_full: assert property (
    (s_r.st == dvl_pkg::DVL_DOWN) && tick && dh_c |=>
    s_r.red <= full_fx)
    else $error("reduction beyond scale");
  a_below_thr: assert property (
    (s_r.st == dvl_pkg::DVL_DOWN) && (demand_pct <= s_r.thr) |=>
    (s_r.st == dvl_pkg::DVL_RECOV))
    else $error("reduction kept below threshold");
  a_thr_disable: assert property (
    (s_r.thr == dvl_pkg::THR_MAX) [*2] |-> ##1 !downhill)
    else $error("threshold at top did not disable");
  a_ramp_step: assert property (
    s_down_tick |=> s_r.red == $past(s_r.red) + $past(step_dn))
    else $error("ramp down step wrong");
  a_rec_step: assert property (
    s_rec_tick |=> s_r.red == $past(s_r.red) - $past(step_rec))
    else $error("recovery step wrong");
  a_defaults: assert property (!s_r.cfg |->
    (s_r.ceil == dvl_pkg::CEIL_DEF) && (s_r.thr == dvl_pkg::THR_DEF) &&
    (s_r.tdn == dvl_pkg::TIME_DEF) && (s_r.trec == dvl_pkg::TIME_DEF))
    else $error("defaults lost before programming");
  a_bus_wait: assert property (
    (read | write) && !s_r.ack |-> waitrequest ##1 !waitrequest)
    else $error("waitrequest not one cycle");
endmodule : dvl_limiter

// ===== hw/dvl_pkg.sv
// Constants, register map and state encoding of the downhill voltage limiter
// How it works
// - Ceiling programmable 0..64 V, default 26.2 V
// - Battery voltage caps ceiling when lower
// - Load compensation may add above ceiling
// - Downhill at high demand and overspeed scales ceiling
// - Reduction is scale/20 volts: 3..5 V, default 3.5 V
// - Reduce only while demand exceeds threshold
// - Threshold 100 percent disables reduction
// - Ramp down over programmable 0.5..2.5 s
// - Recover over separate programmable 0.5..2.5 s
package dvl_pkg;
  // Voltages are in units of 0.1 V, times in units of 0.1 s
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int MS_PER_DS = 100;
  localparam int TICKS_PER_DS = MS_PER_DS * 1000 / TICK_US;
  localparam int FRAC = 10;
  localparam int RED_SHIFT = 1;
  localparam logic [9:0] CEIL_MAX = 10'h280;
  localparam logic [9:0] CEIL_DEF = 10'h106;
  localparam logic [6:0] SCALE_MIN = 7'h3C;
  localparam logic [6:0] SCALE_MAX = 7'h64;
  localparam logic [6:0] SCALE_DEF = 7'h46;
  localparam logic [6:0] THR_MIN = 7'h32;
  localparam logic [6:0] THR_MAX = 7'h64;
  localparam logic [6:0] THR_DEF = 7'h64;
  localparam logic [4:0] TIME_MIN = 5'h05;
  localparam logic [4:0] TIME_MAX = 5'h19;
  localparam logic [4:0] TIME_DEF = 5'h14;
  localparam logic [4:0] ADDR_CEIL = 5'h00;
  localparam logic [4:0] ADDR_SCALE = 5'h04;
  localparam logic [4:0] ADDR_THR = 5'h08;
  localparam logic [4:0] ADDR_TDN = 5'h0C;
  localparam logic [4:0] ADDR_TREC = 5'h10;
  localparam logic [4:0] ADDR_STAT = 5'h14;
  localparam int STAT_DH_BIT = 16;
  localparam int STAT_CFG_BIT = 17;
  typedef enum logic [1:0] {
    DVL_NORMAL = 2'b00,
    DVL_DOWN = 2'b01,
    DVL_RECOV = 2'b10
  } dvl_state_e;
endpackage : dvl_pkg
